// file: rtl/fcsf_pkg.sv
// Constants, register layout and carrier types for the flash command
// status flag block. Assumes an 8-bit register port and one bus clock.
// Function
// RULE1: Normal mode: clearable flags writable, others read-only or zero.
// RULE2: Failure flag writable only in special mode.
// RULE3: Software clears failure flag before new sequence.
// RULE4: Bit 7 shows all buffers empty.
// RULE5: Writing one to bit 7 launches command.
// RULE6: Zero to bit 7 mid-sequence aborts, sets access error.
// RULE7: Zero to bit 7 outside sequence sets nothing.
// RULE8: Buffer-empty interrupt when flag and enable set.
// RULE9: Completion flag low while buffer full, else tracks commands.
// RULE10: Completion stays low when pending command is fetched.
// RULE11: Completion interrupt when flag and enable set.
// RULE12: Bit 5 sets on protected program or erase.
// RULE13: One clears protection flag, zero does nothing.
// RULE14: Protection flag blocks launches and new sequences.
// RULE15: Bit 4 sets on sequence violation, illegal code, fault.
// RULE16: Sector erase abort sets access error.
// RULE17: Stop while command runs sets access error.
// RULE18: One clears access error, zero does nothing.
// RULE19: Access error blocks launches and new sequences.
// RULE20: Fault or verify errors discard buffered command.
// RULE21: Command, address, data form two-stage pipeline.
// RULE22: One write clears several flags together.
// RULE23: Interrupt requests are levels while flag and enable.
`default_nettype none
package fcsf_pkg;

   // Register port geometry.
   localparam int REG_AW = 2;
   localparam int REG_DW = 8;

   // Register offsets.
   localparam logic [REG_AW-1:0] OFS_STATUS = 2'h0;
   localparam logic [REG_AW-1:0] OFS_CONFIG = 2'h1;
   localparam logic [REG_AW-1:0] OFS_CMD    = 2'h2;

   // Status bit positions.
   localparam int BIT_CBE   = 7;
   localparam int BIT_CC    = 6;
   localparam int BIT_PROTECT_VIOLATION_FLAG = 5;
   localparam int BIT_ACC   = 4;
   localparam int BIT_BLANK = 2;
   localparam int BIT_FAIL  = 1;
   localparam int BIT_DFLT  = 0;

   // Configuration bit positions.
   localparam int BIT_CBE_IE = 7;
   localparam int BIT_CC_IE  = 6;

   // Reset values.
   localparam logic [REG_DW-1:0] RST_CONFIG = 8'h00;
   localparam logic [REG_DW-1:0] RST_CMD    = 8'h00;

   // Flash word geometry.
   localparam int FADDR_W = 16;
   localparam int FDATA_W = 16;

   // Command write sequence states.
   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b001,
      SEQ_WORD = 3'b010,
      SEQ_CMD  = 3'b100
   } fcsf_seq_type;

   // Aligned word written into flash space.
   typedef struct packed {
      logic [FADDR_W-1:0] addr;
      logic [FDATA_W-1:0] data;
   } fcsf_word_type;

   // One buffered command.
   typedef struct packed {
      logic [REG_DW-1:0]  code;
      logic [FADDR_W-1:0] addr;
      logic [FDATA_W-1:0] data;
   } fcsf_cmd_type;

endpackage
`default_nettype wire

// file: rtl/fcsf_status.sv
// Status flags, command write sequence and two-stage command pipeline
// for the flash command sequencer. Assumes bus-side strobes are on the
// bus clock; only the mode strap arrives from outside and is synchronised.
//
// Implementation choices: the register addresses and the strobed register port.
`default_nettype none
module fcsf_status
   import fcsf_pkg::*;
(
   // Clock and reset.
   input  wire logic                sys_clk_i,
   input  wire logic                arst_n_i,
   // Register port.
   input  wire logic [REG_AW-1:0]   reg_addr_i,
   input  wire logic [REG_DW-1:0]   reg_wdata_i,
   input  wire logic                reg_wr_i,
   input  wire logic                reg_rd_i,
   output logic      [REG_DW-1:0]   reg_rdata_o,
   // Flash space writes and command checks.
   input  wire logic                flash_wr_i,
   input  wire fcsf_word_type       flash_word_i,
   input  wire logic                flash_protected_i,
   input  wire logic                cmd_illegal_i,
   // Mode and processor events.
   input  wire logic                special_mode_i,
   input  wire logic                cpu_stop_i,
   // Engine side.
   output logic                     launch_o,
   output fcsf_cmd_type             launch_cmd_o,
   input  wire logic                eng_done_i,
   input  wire logic                eng_dfault_i,
   input  wire logic                eng_verify_err_i,
   input  wire logic                eng_erase_abort_i,
   input  wire logic                eng_blank_i,
   input  wire logic                eng_fail_i,
   // Interrupt requests.
   output logic                     cbe_irq_o,
   output logic                     cc_irq_o
);

   fcsf_seq_type  seq_r;
   fcsf_seq_type  seq_nxt;
   fcsf_word_type word_r;
   fcsf_cmd_type  buf_r;
   logic          buf_full_r;
   logic          act_r;
   logic          protect_violation_flag_r;
   logic          access_error_flag_r;
   logic          blank_r;
   logic          fail_r;
   logic          dflt_r;
   logic [REG_DW-1:0] config_r;
   logic [REG_DW-1:0] cmd_r;
   logic          mode_meta_r;
   logic          mode_sync_r;
   logic          cmd_buffer_empty_flag;
   logic          cmd_complete_flag;
   logic          st_wr;
   logic          w1_cbe;
   logic          w0_cbe;
   logic          blocked;
   logic          word_ok;
   logic          cmd_wr;
   logic          launch;
   logic          fetch;
   logic          discard;
   logic          seq_viol;
   logic          protect_violation_flag_set;
   logic          acc_set;
   logic [REG_DW-1:0] status;

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   // The mode strap is a pin level, so it crosses two flip-flops.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         mode_meta_r <= 1'b0;
         mode_sync_r <= 1'b0;
      end else begin
         mode_meta_r <= special_mode_i;
         mode_sync_r <= mode_meta_r;
      end
   end

   // Buffer empty and completion are views of the pipeline occupancy.
   assign cmd_buffer_empty_flag = ~buf_full_r;                       // RULE4
   assign cmd_complete_flag  = ~act_r & ~buf_full_r;              // RULE9

   // Decoded register strobes.
   assign st_wr   = reg_wr_i & (reg_addr_i == OFS_STATUS);
   assign cmd_wr  = reg_wr_i & (reg_addr_i == OFS_CMD);
   assign w1_cbe  = st_wr & reg_wdata_i[BIT_CBE];
   assign w0_cbe  = st_wr & ~reg_wdata_i[BIT_CBE];
   assign blocked = protect_violation_flag_r | access_error_flag_r;              // RULE14 RULE19

   // A sequence only starts on an empty buffer with no error pending.
   assign word_ok = flash_wr_i & (seq_r == SEQ_IDLE) & cmd_buffer_empty_flag & ~blocked;
   assign protect_violation_flag_set = word_ok & flash_protected_i;   // RULE12

   // Out-of-order steps of the write sequence.
   always_comb begin
      seq_viol = 1'b0;
      if (!blocked) begin
         if (flash_wr_i && ((seq_r != SEQ_IDLE) || !cmd_buffer_empty_flag)) begin
            seq_viol = 1'b1;
         end
         if (cmd_wr && (seq_r != SEQ_WORD)) begin
            seq_viol = 1'b1;
         end
         if (cmd_wr && (seq_r == SEQ_WORD) && cmd_illegal_i) begin
            seq_viol = 1'b1;
         end
         if (w1_cbe && (seq_r == SEQ_WORD)) begin
            seq_viol = 1'b1;
         end
      end
      if (w0_cbe && (seq_r != SEQ_IDLE)) begin
         seq_viol = 1'b1;                            // RULE6 RULE7
      end
   end

   // Every access error source; engine faults come first in priority
   // only in the sense that none of them can be masked.
   assign acc_set = seq_viol                         // RULE15
                  | eng_dfault_i | eng_verify_err_i
                  | eng_erase_abort_i                // RULE16
                  | (cpu_stop_i & ~cmd_complete_flag);            // RULE17

   // Launch needs a completed sequence and no error flag.
   assign launch = w1_cbe & (seq_r == SEQ_CMD) & ~blocked;  // RULE5

   // Faults that must not let the pending command run.
   assign discard = eng_dfault_i | eng_verify_err_i;        // RULE20
   assign fetch   = buf_full_r & (~act_r | eng_done_i) & ~discard;

   // Sequence state; any error drops the half-built command.
   always_comb begin
      seq_nxt = seq_r;
      case (seq_r)
         SEQ_IDLE: begin
            if (word_ok && !flash_protected_i) begin
               seq_nxt = SEQ_WORD;
            end
         end
         SEQ_WORD: begin
            if (cmd_wr && !cmd_illegal_i && !blocked) begin
               seq_nxt = SEQ_CMD;
            end
         end
         SEQ_CMD: begin
            if (launch) begin
               seq_nxt = SEQ_IDLE;
            end
         end
         default: begin
            seq_nxt = SEQ_IDLE;
         end
      endcase
      if (acc_set || protect_violation_flag_set) begin
         seq_nxt = SEQ_IDLE;                         // RULE6
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         seq_r <= SEQ_IDLE;
      end else begin
         seq_r <= seq_nxt;
      end
   end

   // Address and data of the sequence are held until launch.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         word_r <= '0;
         cmd_r  <= RST_CMD;
      end else begin
         if (word_ok) begin
            word_r <= flash_word_i;
         end
         if (cmd_wr && (seq_r == SEQ_WORD) && !blocked) begin
            cmd_r <= reg_wdata_i;
         end
      end
   end

   // Buffer stage of the pipeline; a second command waits here while
   // the first runs, so it goes out on launch_o one cycle after eng_done_i.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         buf_full_r <= 1'b0;
         buf_r      <= '0;
      end else begin
         if (launch) begin
            buf_full_r <= 1'b1;                      // RULE21
            buf_r      <= '{code: cmd_r, addr: word_r.addr,
                            data: word_r.data};
         end else if (fetch || discard) begin
            buf_full_r <= 1'b0;                      // RULE20
         end
      end
   end

   // Active stage; a done with a pending fetch keeps it busy.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         act_r        <= 1'b0;
         launch_o     <= 1'b0;
         launch_cmd_o <= '0;
      end else begin
         launch_o <= fetch;
         if (fetch) begin
            act_r        <= 1'b1;                    // RULE10
            launch_cmd_o <= buf_r;
         end else if (eng_done_i) begin
            act_r <= 1'b0;
         end
      end
   end

   // Error flags: a set in the clearing cycle wins over the clear.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         protect_violation_flag_r  <= 1'b0;
         access_error_flag_r <= 1'b0;
         dflt_r   <= 1'b0;
      end else begin
         protect_violation_flag_r  <= protect_violation_flag_set |
                     (protect_violation_flag_r & ~(st_wr & reg_wdata_i[BIT_PROTECT_VIOLATION_FLAG]));
         access_error_flag_r <= acc_set |
                     (access_error_flag_r & ~(st_wr & reg_wdata_i[BIT_ACC]));
         dflt_r   <= eng_dfault_i |
                     (dflt_r & ~(st_wr & reg_wdata_i[BIT_DFLT]));
      end                                            // RULE13 RULE18 RULE22
   end

   // Verify result is read-only; failure is clearable in special mode.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         blank_r <= 1'b0;
         fail_r  <= 1'b0;
      end else begin
         if (eng_blank_i) begin
            blank_r <= 1'b1;
         end else if (launch_o) begin
            blank_r <= 1'b0;
         end
         fail_r <= eng_fail_i |
                   (fail_r & ~(st_wr & mode_sync_r &
                               reg_wdata_i[BIT_FAIL]));   // RULE2
      end
   end

   // Configuration carries the two interrupt enables only.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         config_r <= RST_CONFIG;
      end else if (reg_wr_i && (reg_addr_i == OFS_CONFIG)) begin
         config_r <= '0;
         config_r[BIT_CBE_IE] <= reg_wdata_i[BIT_CBE_IE];
         config_r[BIT_CC_IE]  <= reg_wdata_i[BIT_CC_IE];
      end
   end

   // Status view; failure hides in normal mode, unused bits are zero.
   always_comb begin
      status            = '0;
      status[BIT_CBE]   = cmd_buffer_empty_flag;
      status[BIT_CC]    = cmd_complete_flag;
      status[BIT_PROTECT_VIOLATION_FLAG] = protect_violation_flag_r;
      status[BIT_ACC]   = access_error_flag_r;
      status[BIT_BLANK] = blank_r;
      status[BIT_FAIL]  = fail_r & mode_sync_r;      // RULE1 RULE2
      status[BIT_DFLT]  = dflt_r;
   end

   // Read data stand one cycle after the strobe; unmapped reads zero.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            OFS_STATUS: reg_rdata_o <= status;
            OFS_CONFIG: reg_rdata_o <= config_r;
            OFS_CMD:    reg_rdata_o <= cmd_r;
            default:    reg_rdata_o <= '0;
         endcase
      end else begin
         reg_rdata_o <= '0;
      end
   end

   // Level requests, so a missed edge cannot lose an interrupt.
   assign cbe_irq_o = cmd_buffer_empty_flag & config_r[BIT_CBE_IE];  // RULE8 RULE23
   assign cc_irq_o  = cmd_complete_flag & config_r[BIT_CC_IE];    // RULE11 RULE23

   // Named steps used by the checks below.
   sequence s_launch;
      launch;
   endsequence

   sequence s_mid_abort;
      w0_cbe && (seq_r != SEQ_IDLE);
   endsequence

   sequence s_fetch_on_done;
      act_r && eng_done_i && buf_full_r && !discard;
   endsequence

   a_launch_fills_buffer: assert property (   // RULE5
      s_launch |=> !status[BIT_CBE] ##1 (launch_o || act_r))
      else $error("launch did not fill the buffer");

   a_abort_sets_error: assert property (   // RULE6
      s_mid_abort |=> access_error_flag_r && (seq_r == SEQ_IDLE))
      else $error("mid-sequence zero did not abort");

   a_idle_zero_quiet: assert property (   // RULE7
      w0_cbe && (seq_r == SEQ_IDLE) && !access_error_flag_r && !cpu_stop_i &&
      !eng_dfault_i && !eng_verify_err_i && !eng_erase_abort_i &&
      !flash_wr_i && !cmd_wr |=> !access_error_flag_r)
      else $error("idle zero write set access error");

   a_cc_low_when_full: assert property (   // RULE9
      buf_full_r |-> !cmd_complete_flag && !cc_irq_o)
      else $error("completion set with full buffer");

   a_fetch_keeps_busy: assert property (   // RULE10
      s_fetch_on_done |=> !cmd_complete_flag ##0 launch_o)
      else $error("completion rose on fetch");

   a_protect_violation_flag_blocks: assert property (   // RULE14
      protect_violation_flag_r && flash_wr_i |=> (seq_r == SEQ_IDLE))
      else $error("sequence started under protection error");

   a_access_error_flag_blocks: assert property (   // RULE19
      access_error_flag_r && w1_cbe && !buf_full_r |=> !buf_full_r [*2])
      else $error("command launched under access error");

   a_fault_discards: assert property (   // RULE20
      discard && buf_full_r |=> !buf_full_r && !launch_o)
      else $error("faulted buffer not discarded");

   a_stop_error: assert property (   // RULE17
      cpu_stop_i && !cmd_complete_flag |=> access_error_flag_r)
      else $error("stop during command left no error");

   a_multi_clear: assert property (   // RULE22
      st_wr && reg_wdata_i[BIT_PROTECT_VIOLATION_FLAG] && reg_wdata_i[BIT_ACC] &&
      !protect_violation_flag_set && !acc_set |=> !protect_violation_flag_r && !access_error_flag_r)
      else $error("joint clear missed a flag");

   // Only a launch or a new enable value may drop a raised request.
   a_irq_level: assert property (   // RULE23
      cbe_irq_o && !launch && !(reg_wr_i && (reg_addr_i == OFS_CONFIG))
      |=> cbe_irq_o)
      else $error("buffer interrupt not a level");

   a_cc_irq_level: assert property (   // RULE11
      cc_irq_o && !launch && !(reg_wr_i && (reg_addr_i == OFS_CONFIG))
      |=> cc_irq_o)
      else $error("completion interrupt dropped early");

   a_protect_sets: assert property (   // RULE12
      protect_violation_flag_set |=> protect_violation_flag_r && (seq_r == SEQ_IDLE))
      else $error("protected word left no violation");

   a_order_error: assert property (   // RULE15
      seq_viol |=> access_error_flag_r && (seq_r == SEQ_IDLE))
      else $error("sequence violation left no error");

   a_fault_flag: assert property (   // RULE15
      eng_dfault_i |=> dflt_r && access_error_flag_r)
      else $error("double fault left no flags");

endmodule
`default_nettype wire

// file: verif/fcsf_eng_model.sv
// Behavioural flash engine that sits on the engine side of the status block.
// Assumes one bus clock; each launched command ends after a set delay.
`default_nettype none
module fcsf_eng_model (
   // Clock and reset.
   input  wire logic       sys_clk_i,
   input  wire logic       arst_n_i,
   // Command handshake.
   input  wire logic       launch_i,
   input  wire logic [7:0] dly_i,
   output logic            done_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] cnt_r;

   // Count the busy time down; a long delay lets a second command queue.
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_r  <= 8'h00;
         done_o <= 1'b0;
      end else begin
         done_o <= (cnt_r == 8'h01);
         if (launch_i)
            cnt_r <= dly_i;
         else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
      end
   end
endmodule
`default_nettype wire

// file: verif/fcsf_status_tb_top.sv
// Self-checking bench for the flash command status flag block.
// Assumes the engine model above and the register port of the package.
`default_nettype none
module fcsf_status_tb_top
   import fcsf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              sys_clk_i, arst_n_i, wr, rd, fwr, prot, ill, spec;
   logic              launch, done, cbe_irq, cc_irq, rd_q;
   logic [REG_AW-1:0] addr;
   logic [REG_DW-1:0] wdata, rdata;
   logic [5:0]        ev;
   logic [7:0]        dly;
   fcsf_word_type     word;
   fcsf_cmd_type      lcmd;
   logic [7:0]        rq[$];
   fcsf_cmd_type      lq[$];
   int                errors = 0;
   int                compares = 0;
   int                cyc = 0;
   integer            seed = 32'h810e;

   fcsf_status dut_u (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .flash_wr_i(fwr), .flash_word_i(word),
      .flash_protected_i(prot), .cmd_illegal_i(ill),
      .special_mode_i(spec), .cpu_stop_i(ev[0]), .launch_o(launch),
      .launch_cmd_o(lcmd), .eng_done_i(done), .eng_dfault_i(ev[1]),
      .eng_verify_err_i(ev[2]), .eng_erase_abort_i(ev[3]),
      .eng_blank_i(ev[4]), .eng_fail_i(ev[5]),
      .cbe_irq_o(cbe_irq), .cc_irq_o(cc_irq)
   );

   fcsf_eng_model eng_u (
      .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .launch_i(launch),
      .dly_i(dly), .done_o(done)
   );

   // Free-running bus clock at 100 MHz.
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
   endtask

   // Every driver leaves one idle edge so no strobe is set twice at once.
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      tick(1);
      wr    <= 1'b0;
      tick(1);
   endtask

   task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
      rq.push_back(e);
      addr <= a;
      rd   <= 1'b1;
      tick(1);
      rd   <= 1'b0;
      tick(1);
   endtask

   task automatic flash(input logic p);
      word <= {16'($random(seed)), 16'($random(seed))};
      prot <= p;
      fwr  <= 1'b1;
      tick(1);
      fwr  <= 1'b0;
      tick(1);
   endtask

   task automatic pulse(input int k);
      ev[k] <= 1'b1;
      tick(1);
      ev[k] <= 1'b0;
      tick(1);
   endtask

   // Word, command code, then launch; a refused one must never launch.
   task automatic seq(input logic go);
      logic [7:0] code;
      code = 8'($random(seed));
      flash(1'b0);
      wr_reg(OFS_CMD, code);
      if (go)
         lq.push_back({code, word.addr, word.data});
      wr_reg(OFS_STATUS, 8'h80);
   endtask

   // Levels are looked at mid-cycle, where they have settled; the task
   // hands back on a rising edge so later drives stay edge aligned.
   task automatic irq(input logic b, input logic c);
      @(negedge sys_clk_i);
      chk(40'({cbe_irq, cc_irq}), 40'({b, c}));
      @(posedge sys_clk_i);
   endtask

   task automatic drain();
      for (int i = 0; i < 300; i++)
         if (lq.size() != 0)
            tick(1);
   endtask

   task automatic wrap_up();
      errors += rq.size() + lq.size();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Monitor: read data one cycle after the strobe, launches as they come.
   always @(posedge sys_clk_i) begin
      rd_q <= rd;
      cyc  <= cyc + 1;
      if (rd_q)
         chk(40'(rdata), 40'(rq.pop_front()));
      if (launch && lq.size() == 0)
         chk(40'h1, 40'h0);
      else if (launch)
         chk(lcmd, lq.pop_front());
      if (cyc == 5000) begin
         errors++;
         wrap_up();
      end
   end

   initial begin
      {addr, wdata, wr, rd, fwr, prot, ill, spec, ev} = '0;
      word     = '0;
      dly      = 8'd40;
      arst_n_i = 1'b0;
      tick(6);
      arst_n_i <= 1'b1;
      tick(1);
      // Reset state, unmapped index and read-only bits.
      rd_reg(OFS_STATUS, 8'hC0);
      rd_reg(OFS_CONFIG, 8'h00);
      wr_reg(2'h3, 8'hFF);
      rd_reg(2'h3, 8'h00);
      wr_reg(OFS_STATUS, 8'h40);
      rd_reg(OFS_STATUS, 8'hC0);
      wr_reg(OFS_CONFIG, 8'hC0);
      rd_reg(OFS_CONFIG, 8'hC0);
      irq(1'b1, 1'b1);
      // A slow engine lets a second command wait in the buffer.
      seq(1'b1);
      tick(2);
      irq(1'b1, 1'b0);
      seq(1'b1);
      rd_reg(OFS_STATUS, 8'h00);
      irq(1'b0, 1'b0);
      drain();
      tick(2);
      rd_reg(OFS_STATUS, 8'h80);
      tick(50);
      rd_reg(OFS_STATUS, 8'hC0);
      wr_reg(OFS_CONFIG, 8'h40);
      irq(1'b0, 1'b1);
      // Abort mid-sequence, then prove the error blocks everything.
      flash(1'b0);
      wr_reg(OFS_STATUS, 8'h00);
      rd_reg(OFS_STATUS, 8'hD0);
      seq(1'b0);
      rd_reg(OFS_STATUS, 8'hD0);
      wr_reg(OFS_STATUS, 8'h10);
      rd_reg(OFS_STATUS, 8'hC0);
      // Protected word, blocked sequence, erase abort, joint clear.
      flash(1'b1);
      rd_reg(OFS_STATUS, 8'hE0);
      seq(1'b0);
      rd_reg(OFS_STATUS, 8'hE0);
      pulse(3);
      rd_reg(OFS_STATUS, 8'hF0);
      wr_reg(OFS_STATUS, 8'h30);
      rd_reg(OFS_STATUS, 8'hC0);
      // Illegal code presented with the command write.
      flash(1'b0);
      ill <= 1'b1;
      wr_reg(OFS_CMD, 8'h5A);
      ill <= 1'b0;
      rd_reg(OFS_STATUS, 8'hD0);
      wr_reg(OFS_STATUS, 8'h10);
      // A command code with no word before it is out of order.
      wr_reg(OFS_CMD, 8'h11);
      rd_reg(OFS_STATUS, 8'hD0);
      wr_reg(OFS_STATUS, 8'h10);
      // Stop while busy sets the error; stop while idle does not.
      seq(1'b1);
      tick(2);
      pulse(0);
      rd_reg(OFS_STATUS, 8'h90);
      tick(50);
      wr_reg(OFS_STATUS, 8'h10);
      pulse(0);
      rd_reg(OFS_STATUS, 8'hC0);
      // Double fault, then verify error: the queued command is dropped.
      for (int k = 1; k <= 2; k++) begin
         seq(1'b1);
         seq(1'b0);
         pulse(k);
         tick(60);
         rd_reg(OFS_STATUS, (k == 1) ? 8'hD1 : 8'hD0);
         wr_reg(OFS_STATUS, 8'h11);
      end
      // Failure flag hidden in normal mode, clearable in special mode.
      pulse(5);
      pulse(4);
      rd_reg(OFS_STATUS, 8'hC4);
      spec <= 1'b1;
      tick(4);
      rd_reg(OFS_STATUS, 8'hC6);
      wr_reg(OFS_STATUS, 8'h02);
      rd_reg(OFS_STATUS, 8'hC4);
      spec <= 1'b0;
      tick(4);
      seq(1'b1);
      tick(50);
      rd_reg(OFS_STATUS, 8'hC0);
      tick(2);
      wrap_up();
   end
endmodule
`default_nettype wire
